/* File: design/tfg_defines.svh */
`ifndef TFG_DEFINES_SVH
`define TFG_DEFINES_SVH

`define TFG_FW              24
`define TFG_PW              8
`define TFG_TW              16
`define TFG_SW              8
`define TFG_SRCN            16
`define TFG_MODE_OFF        2'h0
`define TFG_MODE_MASTER     2'h1
`define TFG_MODE_SLAVE      2'h2
`define TFG_SRC_OFFSET      8'h0e
`define TFG_SRC_HANDSHAKE   8'h0f
`define TFG_PCT_DIV         8'h64
`define TFG_CLAMP_KNEE      24'h0003e8
`define TFG_CLAMP_ADD       24'h0000c8
`define TFG_CLAMP_NUM       4'h6
`define TFG_CLAMP_DEN       4'h5
`define TFG_DEF_RUP         16'h0100
`define TFG_DEF_RDN         16'h0100
`define TFG_DEF_AMP         8'h0a
`define TFG_DEF_STEP        8'h02
`define TFG_DEF_HSRC        4'h0
`define TFG_ZERO_F          24'h000000

`endif

/* File: design/tfg_pkg.sv */
package tfg_pkg;
    `include "tfg_defines.svh"

    typedef enum logic [2:0]
    {
        TFG_ST_IDLE = 3'h1,
        TFG_ST_RUN  = 3'h2,
        TFG_ST_HOLD = 3'h4
    } tfg_state_type;

    typedef logic signed [`TFG_FW-1:0] tfg_freq_type;
endpackage

/* File: design/tfg_cfg_if.sv */
`timescale 1ns/1ps
`include "tfg_defines.svh"

interface tfg_cfg_if;
    logic [`TFG_TW-1:0] rup;
    logic [`TFG_TW-1:0] rdn;
    logic [`TFG_PW-1:0] amp;
    logic [`TFG_PW-1:0] step;
    logic [3:0]         hsrc;

    modport owner (output rup, output rdn, output amp, output step, output hsrc);
    modport user  (input rup, input rdn, input amp, input step, input hsrc);
endinterface

/* File: design/tfg_cfg_store.sv */
`timescale 1ns/1ps
`include "tfg_defines.svh"

module tfg_cfg_store
    import tfg_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_running,
    input  wire logic                 i_wr,
    input  wire logic [`TFG_TW-1:0]   i_rup,
    input  wire logic [`TFG_TW-1:0]   i_rdn,
    input  wire logic [`TFG_PW-1:0]   i_amp,
    input  wire logic [`TFG_PW-1:0]   i_step,
    input  wire logic [3:0]           i_hsrc,
    output wire logic                 o_rejected,
    tfg_cfg_if.owner                  cfg
);
    logic rej_reg;

    // Configuration writes are dropped while traverse runs.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cfg.rup  <= `TFG_DEF_RUP;
            cfg.rdn  <= `TFG_DEF_RDN;
            cfg.amp  <= `TFG_DEF_AMP;
            cfg.step <= `TFG_DEF_STEP;
            cfg.hsrc <= `TFG_DEF_HSRC;
        end
        else if (i_wr && !i_running)
        begin
            cfg.rup  <= i_rup;
            cfg.rdn  <= i_rdn;
            cfg.amp  <= i_amp;
            cfg.step <= i_step;
            cfg.hsrc <= i_hsrc;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rej_reg <= 1'b0;
        else
            rej_reg <= i_wr && i_running;
    end

    assign o_rejected = rej_reg;
endmodule

/* File: design/tfg_traverse.sv */
`timescale 1ns/1ps
`include "tfg_defines.svh"

// Contract
// - Mode code 0 disables the generator (reset default), 1 runs it as master and 2 as slave.
// - When enabled the offset is a triangle whose rising and falling slopes come from separate ramp times.
// - As master the offset ramps linearly to the amplitude limit and then reverses.
// - Each reversal adds an immediate step of the proportional step size to the offset.
// - As master the handshake output toggles at each reversal.
// - As slave the slope has the master's magnitude with the opposite sign.
// - As slave, reaching the limit before a handshake change holds the offset until the handshake switches.
// - As slave, a handshake change before the limit reverses the direction at once.
// - Amplitude limit and step are percentages of the selected reference frequency's present value.
// - The offset is added to the frequency reference to give the resulting reference.
// - While traverse runs, writes to the traverse configuration are rejected.
// - The slave's handshake comes from a signal source chosen by configuration.
// - The offset is offered as signal source 14 and the master handshake as source 15.
// - Traverse runs when mode is 1 or 2 (mode 3 leaves it idle), and then the traverse ramp times set the slopes.
// - The sum is clamped to max plus 20 Hz when max is at most 100 Hz, else to 1.2 times max.
module tfg_traverse
    import tfg_pkg::*;
(
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    input  wire logic [1:0]                i_mode,
    input  wire logic                      i_cfg_wr,
    input  wire logic [`TFG_TW-1:0]        i_cfg_rup,
    input  wire logic [`TFG_TW-1:0]        i_cfg_rdn,
    input  wire logic [`TFG_PW-1:0]        i_cfg_amp,
    input  wire logic [`TFG_PW-1:0]        i_cfg_step,
    input  wire logic [3:0]                i_cfg_hsrc,
    input  wire logic signed [`TFG_FW-1:0] i_ref_src,
    input  wire logic signed [`TFG_FW-1:0] i_freq_ref,
    input  wire logic [`TFG_FW-1:0]        i_max_freq,
    input  wire logic [`TFG_SRCN-1:0]      i_hs_sources,
    input  wire logic [`TFG_SW-1:0]        i_src_sel,
    output logic signed [`TFG_FW-1:0]      o_offset,
    output logic                           o_handshake,
    output logic signed [`TFG_FW-1:0]      o_freq_out,
    output logic signed [`TFG_FW-1:0]      o_src_value,
    output logic                           o_active,
    output logic                           o_holding,
    output logic                           o_cfg_rejected
);
    tfg_cfg_if cfg ();

    tfg_state_type            state_reg;
    tfg_state_type            state_next;
    logic [`TFG_SRCN-1:0]     hs_meta_reg;
    logic [`TFG_SRCN-1:0]     hs_sync_reg;
    logic                     hs_sel_reg;
    logic                     hs_prev_reg;
    logic                     up_reg;
    logic [`TFG_TW-1:0]       tick_reg;
    tfg_freq_type             off_reg;
    tfg_freq_type             off_next;
    logic                     up_next;
    logic                     toggle;
    logic                     hs_reg;
    tfg_freq_type             sum_reg;
    tfg_freq_type             src_reg;
    logic                     rej_w;
    logic                     running;
    tfg_freq_type             amp_lim;
    tfg_freq_type             step_sz;
    tfg_freq_type             ceil_f;
    logic                     hs_edge;
    logic [`TFG_TW-1:0]       period;
    logic                     is_master;
    logic                     is_slave;
    logic                     at_limit;
    logic                     tick_due;
    tfg_freq_type             sum_w;

    function automatic tfg_freq_type pct(input tfg_freq_type base, input logic [`TFG_PW-1:0] p);
        logic [`TFG_FW-1:0]         mag;
        logic [`TFG_FW+`TFG_PW-1:0] prod;
        mag  = base[`TFG_FW-1] ? `TFG_FW'(-base) : `TFG_FW'(base);
        prod = (`TFG_FW+`TFG_PW)'(mag) * (`TFG_FW+`TFG_PW)'(p);
        return tfg_freq_type'(prod / (`TFG_FW+`TFG_PW)'(`TFG_PCT_DIV));
    endfunction

    // A reversal steps the offset against the slope that was running.
    function automatic tfg_freq_type rev_step(input tfg_freq_type off, input logic up, input tfg_freq_type stp);
        return up ? off - stp : off + stp;
    endfunction

    assign is_master = (i_mode == `TFG_MODE_MASTER);
    assign is_slave  = (i_mode == `TFG_MODE_SLAVE);
    assign running   = is_master || is_slave;

    tfg_cfg_store u_cfg
    (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_running  (running),
        .i_wr       (i_cfg_wr),
        .i_rup      (i_cfg_rup),
        .i_rdn      (i_cfg_rdn),
        .i_amp      (i_cfg_amp),
        .i_step     (i_cfg_step),
        .i_hsrc     (i_cfg_hsrc),
        .o_rejected (rej_w),
        .cfg        (cfg)
    );

    // Limit and step scale with the magnitude of the selected reference.
    assign amp_lim  = pct(i_ref_src, cfg.amp);
    assign step_sz  = pct(i_ref_src, cfg.step);
    assign period   = up_reg ? cfg.rup : cfg.rdn;
    assign tick_due = (tick_reg >= period);
    assign at_limit = (up_reg && off_reg >= amp_lim) || (!up_reg && off_reg <= -amp_lim);
    assign sum_w    = i_freq_ref + off_reg;

    // Every candidate pin passes two flip-flops before any selection logic.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hs_meta_reg <= '0;
            hs_sync_reg <= '0;
        end
        else
        begin
            hs_meta_reg <= i_hs_sources;
            hs_sync_reg <= hs_meta_reg;
        end
    end

    // The configured source is picked, then kept one more cycle for edge detection.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hs_sel_reg  <= 1'b0;
            hs_prev_reg <= 1'b0;
        end
        else
        begin
            hs_sel_reg  <= hs_sync_reg[cfg.hsrc];
            hs_prev_reg <= hs_sel_reg;
        end
    end

    assign hs_edge = is_slave && (hs_sel_reg != hs_prev_reg);

    // Slope tick: one offset unit every ramp period plus one cycles in the active direction.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            tick_reg <= '0;
        else if (!running || toggle || tick_due)
            tick_reg <= '0;
        else
            tick_reg <= tick_reg + `TFG_TW'(1);
    end

    // Next state, offset and direction; a handshake edge outranks the limit.
    always_comb
    begin
        state_next = state_reg;
        off_next   = off_reg;
        up_next    = up_reg;
        toggle     = 1'b0;
        case (state_reg)
            TFG_ST_IDLE:
            begin
                off_next = `TFG_ZERO_F;
                up_next  = is_master;
                if (running)
                    state_next = TFG_ST_RUN;
            end
            TFG_ST_RUN:
            begin
                if (!running)
                    state_next = TFG_ST_IDLE;
                else if (hs_edge)
                    toggle = 1'b1;
                else if (at_limit)
                begin
                    if (is_master)
                        toggle = 1'b1;
                    else
                        state_next = TFG_ST_HOLD;
                end
                else if (tick_due && up_reg)
                    off_next = off_reg + tfg_freq_type'(1);
                else if (tick_due)
                    off_next = off_reg - tfg_freq_type'(1);
                if (toggle)
                begin
                    up_next  = !up_reg;
                    off_next = rev_step(off_reg, up_reg, step_sz);
                end
            end
            TFG_ST_HOLD:
            begin
                if (!running)
                    state_next = TFG_ST_IDLE;
                else if (hs_edge)
                begin
                    toggle     = 1'b1;
                    state_next = TFG_ST_RUN;
                    up_next    = !up_reg;
                    off_next   = rev_step(off_reg, up_reg, step_sz);
                end
            end
            default:
                state_next = TFG_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_reg <= TFG_ST_IDLE;
        else
            state_reg <= state_next;
    end

    // Offset register; it is the traverse output itself.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            off_reg <= `TFG_ZERO_F;
        else
            off_reg <= off_next;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            up_reg <= 1'b1;
        else
            up_reg <= up_next;
    end

    // Master handshake toggles on each reversal.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            hs_reg <= 1'b0;
        else if (toggle && is_master)
            hs_reg <= !hs_reg;
    end

    // Summed reference with upper clamp.
    always_comb
    begin
        if (i_max_freq <= `TFG_CLAMP_KNEE)
            ceil_f = tfg_freq_type'(i_max_freq + `TFG_CLAMP_ADD);
        else
            ceil_f = tfg_freq_type'((i_max_freq * `TFG_FW'(`TFG_CLAMP_NUM)) / `TFG_FW'(`TFG_CLAMP_DEN));
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            sum_reg <= `TFG_ZERO_F;
        else if (sum_w > ceil_f)
            sum_reg <= ceil_f;
        else
            sum_reg <= sum_w;
    end

    // Internal signal source routing.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            src_reg <= `TFG_ZERO_F;
        else if (i_src_sel == `TFG_SRC_OFFSET)
            src_reg <= off_reg;
        else if (i_src_sel == `TFG_SRC_HANDSHAKE)
            src_reg <= tfg_freq_type'(hs_reg);
        else
            src_reg <= `TFG_ZERO_F;
    end

    // Running flag, one cycle behind the mode input.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_active <= 1'b0;
        else
            o_active <= running;
    end

    // Holding flag rises with the hold state itself.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_holding <= 1'b0;
        else
            o_holding <= (state_next == TFG_ST_HOLD);
    end

    // Refusal pulse, one cycle after the store has dropped a write.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_cfg_rejected <= 1'b0;
        else
            o_cfg_rejected <= rej_w;
    end

    assign o_offset    = off_reg;
    assign o_handshake = hs_reg;
    assign o_freq_out  = sum_reg;
    assign o_src_value = src_reg;
endmodule

/* File: tb/tfg_traverse_asserts.sv */
`timescale 1ns/1ps
`include "tfg_defines.svh"
module tfg_traverse_asserts
    import tfg_pkg::*;
(
    input wire logic                      i_clk,
    input wire logic                      i_rst_n,
    input wire logic [1:0]                i_mode,
    input wire logic                      i_cfg_wr,
    input wire logic signed [`TFG_FW-1:0] i_freq_ref,
    input wire logic [`TFG_FW-1:0]        i_max_freq,
    input wire logic [`TFG_SW-1:0]        i_src_sel,
    input wire logic signed [`TFG_FW-1:0] o_offset,
    input wire logic                      o_handshake,
    input wire logic signed [`TFG_FW-1:0] o_freq_out,
    input wire logic signed [`TFG_FW-1:0] o_src_value,
    input wire logic                      o_active,
    input wire logic                      o_holding,
    input wire logic                      o_cfg_rejected
);
    logic signed [`TFG_FW-1:0] lim;
    // Upper limit of the summed frequency for the present maximum.
    assign lim = (i_max_freq <= `TFG_CLAMP_KNEE) ? i_max_freq + `TFG_CLAMP_ADD
                                                 : i_max_freq * `TFG_CLAMP_NUM / `TFG_CLAMP_DEN;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_idle;
        (i_mode == `TFG_MODE_OFF) [*3] |-> o_offset == 0 && !o_active;
    endproperty
    a_idle: assert property (p_idle) else $error("offset not cleared while off");
    property p_active;
        (i_mode == `TFG_MODE_MASTER || i_mode == `TFG_MODE_SLAVE) |=> o_active;
    endproperty
    a_active: assert property (p_active) else $error("not active in a running mode");
    property p_hs_slave;
        $changed(o_handshake) |-> $past(i_mode) != `TFG_MODE_SLAVE;
    endproperty
    a_hs_slave: assert property (p_hs_slave) else $error("handshake moved in slave mode");
    property p_step;
        $changed(o_handshake) |-> o_offset != $past(o_offset);
    endproperty
    a_step: assert property (p_step) else $error("no step at reversal");
    property p_sum;
        $past(i_rst_n) && $stable(i_freq_ref) && $stable(i_max_freq) && (i_freq_ref + $past(o_offset)) < lim
        |-> o_freq_out == i_freq_ref + $past(o_offset);
    endproperty
    a_sum: assert property (p_sum) else $error("sum of offset and reference wrong");
    property p_clamp;
        $past(i_rst_n) && $stable(i_max_freq) |-> o_freq_out <= lim;
    endproperty
    a_clamp: assert property (p_clamp) else $error("summed frequency above limit");
    property p_src14;
        $past(i_rst_n) && $past(i_src_sel) == `TFG_SRC_OFFSET |-> o_src_value == $past(o_offset);
    endproperty
    a_src14: assert property (p_src14) else $error("source 14 not the offset");
    property p_src15;
        $past(i_rst_n) && $past(i_src_sel) == `TFG_SRC_HANDSHAKE |-> o_src_value == {23'h0, $past(o_handshake)};
    endproperty
    a_src15: assert property (p_src15) else $error("source 15 not the handshake");
    property p_reject;
        o_active && i_mode != `TFG_MODE_OFF && i_cfg_wr |=> ##1 o_cfg_rejected;
    endproperty
    a_reject: assert property (p_reject) else $error("write while running not refused");
    property p_hold;
        $past(o_holding) && o_holding |-> $stable(o_offset);
    endproperty
    a_hold: assert property (p_hold) else $error("offset moved while holding");
endmodule
bind tfg_traverse tfg_traverse_asserts tfg_traverse_asserts_inst (.*);

/* File: tb/tfg_peer_master.sv */
`timescale 1ns/1ps
module tfg_peer_master
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic [7:0] i_period,
    output logic            o_hs
);
    logic [7:0] cnt_reg;
    // Toggles the handshake every period plus one cycles; period zero keeps it still.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_reg <= 8'h00;
            o_hs    <= 1'b0;
        end
        else if (i_period != 8'h00)
        begin
            cnt_reg <= (cnt_reg >= i_period) ? 8'h00 : cnt_reg + 8'h01;
            o_hs    <= (cnt_reg >= i_period) ? ~o_hs : o_hs;
        end
    end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "tfg_defines.svh"
module tb
    import tfg_pkg::*;
;
    logic               i_clk = 1'b0, i_rst_n = 1'b0, i_cfg_wr = 1'b0, peer_hs;
    logic               o_handshake, o_active, o_holding, o_cfg_rejected;
    logic [1:0]         i_mode = `TFG_MODE_OFF;
    logic [3:0]         i_cfg_hsrc = 4'h3;
    logic [7:0]         i_cfg_amp = 8'h0a, i_cfg_step = 8'h02, i_src_sel = `TFG_SRC_OFFSET, peer_period = 8'h00;
    logic [15:0]        i_cfg_rup = 16'h0001, i_cfg_rdn = 16'h0001;
    logic [23:0]        i_max_freq = 24'h0007d0;
    logic signed [23:0] i_ref_src = 24'h000064, i_freq_ref = 24'h0001f4;
    logic signed [23:0] o_offset, o_freq_out, o_src_value;
    int                 fail_count = 0, samples_checked = 0;
    tfg_traverse tfg_traverse_inst (.*, .i_hs_sources({12'h000, peer_hs, 3'h0}));
    tfg_peer_master tfg_peer_master_inst (.i_clk, .i_rst_n, .i_period(peer_period), .o_hs(peer_hs));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d fails=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cfg_write(input logic [7:0] amp);
        @(posedge i_clk);
        i_cfg_wr  <= 1'b1;
        i_cfg_amp <= amp;
        @(posedge i_clk);
        i_cfg_wr  <= 1'b0;
        @(negedge i_clk);
    endtask
    task automatic test_idle();
        logic [23:0] tab [4][3] = '{'{24'h0001f4, 24'h0003e8, 24'h0002bc}, '{24'h0003e8, 24'h0005dc, 24'h0004b0},
                                    '{24'h0007d0, 24'h000bb8, 24'h000960}, '{24'h0007d0, 24'h0003e8, 24'h0003e8}};
        check(o_offset, 24'h000000);
        check(o_active, 1'b0);
        cfg_write(8'h0a);
        check(o_cfg_rejected, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge i_clk);
            i_max_freq <= tab[k][0];
            i_freq_ref <= tab[k][1];
            repeat (2) @(posedge i_clk);
            @(negedge i_clk);
            check(o_freq_out, tab[k][2]);
        end
        @(posedge i_clk);
        i_max_freq <= 24'h0007d0;
        i_freq_ref <= 24'h0001f4;
    endtask
    task automatic test_master();
        logic [23:0] peak = 24'h000000;
        logic        hs0;
        int          n = 0;
        @(posedge i_clk);
        i_mode <= `TFG_MODE_MASTER;
        cfg_write(8'h20);
        @(negedge i_clk);
        check(o_cfg_rejected, 1'b1);
        check(o_active, 1'b1);
        hs0 = o_handshake;
        while (o_handshake === hs0 && n < 200)
        begin
            @(negedge i_clk);
            peak = ($signed(o_offset) > $signed(peak)) ? o_offset : peak;
            n++;
        end
        check(n < 200, 1'b1);
        check(peak, 24'h00000a);
        check(o_offset, 24'h000008);
        repeat (8) @(negedge i_clk);
        check($signed(o_offset) < 8, 1'b1);
        @(posedge i_clk);
        i_src_sel <= `TFG_SRC_HANDSHAKE;
        @(posedge i_clk);
        @(negedge i_clk);
        check(o_src_value, 24'h000001);
        @(posedge i_clk);
        i_src_sel <= `TFG_SRC_OFFSET;
        i_mode    <= `TFG_MODE_OFF;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        check(o_offset, 24'h000000);
    endtask
    task automatic test_slave();
        logic [23:0] m;
        int          n = 0;
        @(posedge i_clk);
        i_mode <= `TFG_MODE_SLAVE;
        while (o_holding !== 1'b1 && n < 300)
        begin
            @(negedge i_clk);
            n++;
        end
        check(o_offset, 24'hfffff6);
        check(o_holding, 1'b1);
        repeat (6) @(negedge i_clk);
        check(o_offset, 24'hfffff6);
        @(posedge i_clk);
        peer_period <= 8'h07;
        n = 0;
        while (o_holding === 1'b1 && n < 20)
        begin
            @(negedge i_clk);
            n++;
        end
        check(o_offset, 24'hfffff8);
        check(o_holding, 1'b0);
        m = o_offset;
        n = 0;
        while ($signed(o_offset) >= $signed(m) && n < 40)
        begin
            m = o_offset;
            @(negedge i_clk);
            n++;
        end
        check(n < 40, 1'b1);
        check(o_offset, m - 24'h000002);
        @(posedge i_clk);
        peer_period <= 8'h00;
        i_mode      <= `TFG_MODE_OFF;
    endtask
    initial
    begin
        forever #2.5 i_clk = ~i_clk;
    end
    initial
    begin
        #20000;
        fail_count++;
        print_verdict();
    end
    initial
    begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(negedge i_clk);
        test_idle();
        test_master();
        test_slave();
        repeat (4) @(posedge i_clk);
        print_verdict();
    end
endmodule
